// ---- src/sebfe_pkg.sv ----
// Shared constants and types for the two-wire EEPROM front end and its bus master.
// Assumes a 20 MHz system clock at both ends.
package sebfe_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int SYS_CLK_HZ = 20_000_000;
  localparam int SYS_CLK_NS = 50;
  localparam int GLITCH_FILTER_WIDTH_NS = 50;
  localparam int GLITCH_FILTER_RAW = (GLITCH_FILTER_WIDTH_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int GLITCH_FILTER_CYCLES = (GLITCH_FILTER_RAW < 1) ? 1 : GLITCH_FILTER_RAW;
  localparam int INTERNAL_PROGRAM_TIME_MS = 5;
  localparam int INTERNAL_PROGRAM_CYCLES = INTERNAL_PROGRAM_TIME_MS * (SYS_CLK_HZ / 1000);

  // Slave clock rate limits of the speed grades, in kHz
  localparam int SLAVE_CLOCK_RATE_STD_KHZ = 100;
  localparam int SLAVE_CLOCK_RATE_FAST_KHZ = 400;
  localparam int SLAVE_CLOCK_RATE_FPLUS_KHZ = 1000;
  // Half clock periods, rounded up so the rate never exceeds its limit
  localparam int HALF_STD_RAW = (SYS_CLK_HZ + 2000 * SLAVE_CLOCK_RATE_STD_KHZ - 1)
                                / (2000 * SLAVE_CLOCK_RATE_STD_KHZ);
  localparam int HALF_FAST_RAW = (SYS_CLK_HZ + 2000 * SLAVE_CLOCK_RATE_FAST_KHZ - 1)
                                 / (2000 * SLAVE_CLOCK_RATE_FAST_KHZ);
  localparam int HALF_FPLUS_RAW = (SYS_CLK_HZ + 2000 * SLAVE_CLOCK_RATE_FPLUS_KHZ - 1)
                                  / (2000 * SLAVE_CLOCK_RATE_FPLUS_KHZ);
  localparam logic [7:0] HALF_STD_CYCLES = HALF_STD_RAW[7:0];
  localparam logic [7:0] HALF_FAST_CYCLES = HALF_FAST_RAW[7:0];
  localparam logic [7:0] HALF_FPLUS_CYCLES = HALF_FPLUS_RAW[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Address word and framing
  localparam logic [3:0] TYPE_CODE_DEFAULT = 4'h6;   // Arbitrary value
  localparam logic [2:0] SELECT_DEFAULT = 3'h3;      // Arbitrary value
  localparam int MEM_ADDR_W = 12;
  localparam int PAGE_BITS = 5;
  localparam logic [3:0] BIT_DATA_LAST = 4'h8;
  localparam logic [3:0] BIT_ACK_CLOCK = 4'h9;
  localparam logic [3:0] BIT_FIRST = 4'h1;
  localparam logic [3:0] BIT_ZERO = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Enumerations
  typedef enum logic [1:0] {
    GRADE_STD = 2'b00,
    GRADE_FAST = 2'b01,
    GRADE_FPLUS = 2'b10
  } sebfe_grade_type;

  typedef enum logic [1:0] {
    CMD_START = 2'b00,
    CMD_STOP = 2'b01,
    CMD_WRITE = 2'b10,
    CMD_READ = 2'b11
  } sebfe_cmd_type;

  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_DEVADDR = 3'b001,
    D_ADDR_HI = 3'b010,
    D_ADDR_LO = 3'b011,
    D_WDATA = 3'b100,
    D_RDATA = 3'b101
  } sebfe_dev_state_type;

  typedef enum logic [3:0] {
    M_IDLE = 4'b0000,
    M_SA = 4'b0001,
    M_SB = 4'b0010,
    M_SC = 4'b0011,
    M_SD = 4'b0100,
    M_PA = 4'b0101,
    M_PB = 4'b0110,
    M_PC = 4'b0111,
    M_BL = 4'b1000,
    M_BH = 4'b1001
  } sebfe_mst_state_type;

endpackage

// ---- src/sebfe_link_if.sv ----
// Two-wire link between the bus master end and the EEPROM end.
// Resolves the open-drain data line from both enables; resistor pulls it high.
`timescale 1ns/10ps
interface sebfe_link_if;
  logic scl;
  logic m_sda_out;
  logic m_sda_oe;
  logic d_sda_out;
  logic d_sda_oe;
  logic sda;

  // Wired-AND of both drivers with a pull-up
  assign sda = ~((m_sda_oe & ~m_sda_out) | (d_sda_oe & ~d_sda_out));

  modport slave(input scl, input sda, output d_sda_out, output d_sda_oe);
  modport master(output scl, output m_sda_out, output m_sda_oe, input sda);
endinterface

// ---- src/sebfe_slave_end.sv ----
// EEPROM slave end of the two-wire front end: sampling, filtering, framing,
// acknowledge, read shifting and the write-protected program launch.
// Assumes the memory array outside answers rd_data_in for rd_addr_out within one cycle.
`timescale 1ns/10ps

// Function
// RULE1: Sample data on each serial clock rise.
// RULE2: Change driven data only after clock falls.
// RULE3: Data line open-drain, pull low or release.
// RULE4: Protect high refuses any memory alteration.
// RULE5: Protect low permits normal programming.
// RULE6: Reads served whatever the protect level.
// RULE7: Master starts with data falling, clock high.
// RULE8: Filter glitches on clock and data inputs.
// RULE9: Master keeps clock within speed grade limit.
// RULE10: Master controls transfer, memory is slave.
// RULE11: Stop ends transfer; write stop launches programming.
// RULE12: Receiver pulls data low on ninth clock.
// RULE13: Acknowledge address only on code match.
// RULE14: Sample protect at program launch, skip if set.
module sebfe_slave_end
  import sebfe_pkg::*;
#(
  parameter int PROG_CYCLES = INTERNAL_PROGRAM_CYCLES,
  parameter int FILT_CYCLES = GLITCH_FILTER_CYCLES,
  parameter logic [3:0] TYPE_CODE = TYPE_CODE_DEFAULT,
  parameter logic [2:0] SELECT_CODE = SELECT_DEFAULT,
  parameter int ADDR_W = MEM_ADDR_W
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // Two-wire link
  sebfe_link_if.slave link,
  // Write protect pin
  input wire logic wp_in,
  // Memory array side
  output logic [ADDR_W-1:0] rd_addr_out,
  input wire logic [7:0] rd_data_in,
  output logic prog_out,
  output logic [ADDR_W-1:0] prog_addr_out,
  output logic [7:0] prog_data_out,
  output logic protect_refused_out,
  output logic busy_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Input sampling and glitch filtering
  logic [1:0] raw_pins;
  logic [1:0] filt_pins;
  logic [1:0] prev_reg;
  logic wp_sync1_reg;
  logic wp_sync2_reg;

  assign raw_pins = {link.scl, link.sda};

  // Two flip-flops, then a level is accepted only after it outlasts the glitch width
  for (genvar i = 0; i < 2; i++) begin : g_filt
    logic sync1_reg;
    logic sync2_reg;
    logic level_reg;
    logic [7:0] cnt_reg;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
        sync1_reg <= 1'b1;
        sync2_reg <= 1'b1;
        level_reg <= 1'b1;
        cnt_reg <= 8'h00;
      end else begin
        sync1_reg <= raw_pins[i];
        sync2_reg <= sync1_reg;
        if (sync2_reg == level_reg) begin
          cnt_reg <= 8'h00;
        end else if (cnt_reg == 8'(FILT_CYCLES)) begin  // see RULE8
          level_reg <= sync2_reg;
          cnt_reg <= 8'h00;
        end else begin
          cnt_reg <= cnt_reg + 8'h01;
        end
      end
    end
    assign filt_pins[i] = level_reg;
  end

  // Protect pin synchroniser and edge history
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wp_sync1_reg <= 1'b0;
      wp_sync2_reg <= 1'b0;
      prev_reg <= 2'b11;
    end else begin
      wp_sync1_reg <= wp_in;
      wp_sync2_reg <= wp_sync1_reg;
      prev_reg <= filt_pins;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus events
  logic scl_f;
  logic sda_f;
  logic scl_rise;
  logic scl_fall;
  logic start_evt;
  logic stop_evt;
  logic ack_slot_fall;
  logic byte_end_fall;
  logic addr_match;
  logic prog_busy;

  assign scl_f = filt_pins[1];
  assign sda_f = filt_pins[0];
  assign scl_rise = scl_f & ~prev_reg[1];
  assign scl_fall = ~scl_f & prev_reg[1];
  // Data edges while the clock stays high frame a transfer
  assign start_evt = scl_f & prev_reg[1] & prev_reg[0] & ~sda_f;  // see RULE7
  assign stop_evt = scl_f & prev_reg[1] & ~prev_reg[0] & sda_f;   // see RULE11

  ////////////////////////////////////////////////////////////////////////////
  // Bit counter and receive shifter
  sebfe_dev_state_type state_reg;
  logic [3:0] bit_reg;
  logic [7:0] rx_reg;
  logic [7:0] tx_reg;
  logic mack_reg;
  logic sda_low_reg;

  assign ack_slot_fall = scl_fall & (bit_reg == BIT_DATA_LAST);
  assign byte_end_fall = scl_fall & (bit_reg == BIT_ACK_CLOCK);
  assign addr_match = (rx_reg[7:4] == TYPE_CODE) & (rx_reg[3:1] == SELECT_CODE) & ~prog_busy;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bit_reg <= BIT_ZERO;
      rx_reg <= 8'h00;
      mack_reg <= 1'b0;
    end else if (start_evt || stop_evt) begin
      bit_reg <= BIT_ZERO;
    end else if (scl_rise) begin
      if (bit_reg < BIT_ACK_CLOCK) begin
        bit_reg <= bit_reg + BIT_FIRST;
      end
      if (bit_reg < BIT_DATA_LAST) begin
        rx_reg <= {rx_reg[6:0], sda_f};  // see RULE1
      end
      if (bit_reg == BIT_DATA_LAST) begin
        mack_reg <= ~sda_f;  // Master acknowledge of read data
      end
    end else if (byte_end_fall) begin
      bit_reg <= BIT_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer state machine; the master paces every step
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin  // see RULE10
    if (!resetn_in) begin
      state_reg <= D_IDLE;
    end else if (start_evt) begin
      state_reg <= D_DEVADDR;
    end else if (stop_evt) begin
      state_reg <= D_IDLE;  // see RULE11
    end else if (ack_slot_fall && state_reg == D_DEVADDR && !addr_match) begin
      state_reg <= D_IDLE;  // see RULE13
    end else if (byte_end_fall) begin
      case (state_reg)
        D_DEVADDR: state_reg <= rx_reg[0] ? D_RDATA : D_ADDR_HI;  // see RULE6
        D_ADDR_HI: state_reg <= D_ADDR_LO;
        D_ADDR_LO: state_reg <= D_WDATA;
        D_WDATA: state_reg <= D_WDATA;
        D_RDATA: state_reg <= mack_reg ? D_RDATA : D_IDLE;
        default: state_reg <= D_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data line drive, updated only on clock falls or framing events
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sda_low_reg <= 1'b0;
      tx_reg <= 8'h00;
    end else if (start_evt || stop_evt) begin
      sda_low_reg <= 1'b0;
    end else if (ack_slot_fall) begin
      case (state_reg)
        D_DEVADDR: sda_low_reg <= addr_match;  // see RULE12
        D_ADDR_HI: sda_low_reg <= 1'b1;
        D_ADDR_LO: sda_low_reg <= 1'b1;
        D_WDATA: sda_low_reg <= 1'b1;
        default: sda_low_reg <= 1'b0;  // Master acknowledges read data
      endcase
    end else if (byte_end_fall) begin
      if ((state_reg == D_DEVADDR && rx_reg[0]) || (state_reg == D_RDATA && mack_reg)) begin
        tx_reg <= rd_data_in;
        sda_low_reg <= ~rd_data_in[7];  // see RULE2
      end else begin
        sda_low_reg <= 1'b0;
      end
    end else if (scl_fall && state_reg == D_RDATA && bit_reg >= BIT_FIRST &&
                 bit_reg < BIT_DATA_LAST) begin
      tx_reg <= {tx_reg[6:0], 1'b0};
      sda_low_reg <= ~tx_reg[6];  // see RULE2
    end
  end

  // Open drain: only ever pull low or release
  assign link.d_sda_out = 1'b0;  // see RULE3
  assign link.d_sda_oe = sda_low_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Address counter and pending write byte
  logic [ADDR_W-1:0] addr_reg;
  logic pend_valid_reg;
  logic [ADDR_W-1:0] pend_addr_reg;
  logic [7:0] pend_data_reg;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      addr_reg <= '0;
      pend_valid_reg <= 1'b0;
      pend_addr_reg <= '0;
      pend_data_reg <= 8'h00;
    end else if (start_evt || stop_evt) begin
      pend_valid_reg <= 1'b0;
    end else if (scl_rise && bit_reg == BIT_DATA_LAST && state_reg == D_RDATA) begin
      addr_reg <= addr_reg + 1'b1;  // Sequential read wraps over the whole array
    end else if (byte_end_fall) begin
      case (state_reg)
        D_ADDR_HI: addr_reg[ADDR_W-1:8] <= rx_reg[ADDR_W-9:0];
        D_ADDR_LO: addr_reg[7:0] <= rx_reg;
        D_WDATA: begin
          pend_valid_reg <= 1'b1;
          pend_addr_reg <= addr_reg;
          pend_data_reg <= rx_reg;
          addr_reg[PAGE_BITS-1:0] <= addr_reg[PAGE_BITS-1:0] + 1'b1;  // Wrap in page
        end
        default: addr_reg <= addr_reg;
      endcase
    end
  end

  assign rd_addr_out = addr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Program launch and internal program timer
  logic [31:0] prog_cnt_reg;
  logic prog_reg;
  logic refused_reg;
  logic [ADDR_W-1:0] prog_addr_reg;
  logic [7:0] prog_data_reg;
  logic launch;

  assign prog_busy = (prog_cnt_reg != 32'h0000_0000);
  assign launch = stop_evt & (state_reg == D_WDATA) & pend_valid_reg;  // see RULE11

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prog_cnt_reg <= 32'h0000_0000;
      prog_reg <= 1'b0;
      refused_reg <= 1'b0;
      prog_addr_reg <= '0;
      prog_data_reg <= 8'h00;
    end else begin
      prog_reg <= 1'b0;
      refused_reg <= 1'b0;
      if (launch && wp_sync2_reg) begin
        refused_reg <= 1'b1;  // see RULE4, RULE14
      end else if (launch) begin
        prog_reg <= 1'b1;  // see RULE5
        prog_addr_reg <= pend_addr_reg;
        prog_data_reg <= pend_data_reg;
        prog_cnt_reg <= 32'(PROG_CYCLES);
      end else if (prog_busy) begin
        prog_cnt_reg <= prog_cnt_reg - 32'h0000_0001;
      end
    end
  end

  assign prog_out = prog_reg;
  assign prog_addr_out = prog_addr_reg;
  assign prog_data_out = prog_data_reg;
  assign protect_refused_out = refused_reg;
  assign busy_out = prog_busy;

endmodule

// ---- src/sebfe_master_end.sv ----
// Bus master end of the two-wire link: start, stop, byte write and byte read.
// Assumes a slave that never stretches the clock; clock is driven push-pull.
`timescale 1ns/10ps
module sebfe_master_end
  import sebfe_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // Command side
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire sebfe_cmd_type cmd_kind_in,
  input wire logic [7:0] cmd_data_in,
  input wire logic cmd_ack_in,
  input wire sebfe_grade_type grade_in,
  // Answer side
  output logic done_out,
  output logic [7:0] rsp_data_out,
  output logic rsp_ack_out,
  // Two-wire link
  sebfe_link_if.master link
);

  ////////////////////////////////////////////////////////////////////////////
  // Data line synchroniser and half-period select
  logic sda_sync1_reg;
  logic sda_sync2_reg;
  logic [7:0] half_cyc;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sda_sync1_reg <= 1'b1;
      sda_sync2_reg <= 1'b1;
    end else begin
      sda_sync1_reg <= link.sda;
      sda_sync2_reg <= sda_sync1_reg;
    end
  end

  // Clock never runs above the grade's limit
  always_comb begin  // see RULE9
    case (grade_in)
      GRADE_FAST: half_cyc = HALF_FAST_CYCLES;
      GRADE_FPLUS: half_cyc = HALF_FPLUS_CYCLES;
      default: half_cyc = HALF_STD_CYCLES;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: each state but M_IDLE lasts one half period; M_BL changes the data line in its second cycle
  sebfe_mst_state_type state_reg;
  logic [7:0] tmr_reg;
  logic scl_reg;
  logic sda_low_reg;
  logic [3:0] bit_reg;
  logic [8:0] tx_reg;
  logic [7:0] rx_reg;
  logic done_reg;
  logic [7:0] rsp_data_reg;
  logic rsp_ack_reg;
  logic tick;

  assign tick = (tmr_reg == half_cyc - 8'h01);

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin  // see RULE10
    if (!resetn_in) begin
      state_reg <= M_IDLE;
      tmr_reg <= 8'h00;
      scl_reg <= 1'b1;
      sda_low_reg <= 1'b0;
      bit_reg <= BIT_ZERO;
      tx_reg <= 9'h1ff;
      rx_reg <= 8'h00;
      done_reg <= 1'b0;
      rsp_data_reg <= 8'h00;
      rsp_ack_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      tmr_reg <= tick ? 8'h00 : tmr_reg + 8'h01;
      case (state_reg)
        M_IDLE: begin
          tmr_reg <= 8'h00;
          if (cmd_valid_in) begin
            bit_reg <= BIT_ZERO;
            case (cmd_kind_in)
              CMD_START: begin
                sda_low_reg <= 1'b0;
                state_reg <= M_SA;
              end
              CMD_STOP: begin
                sda_low_reg <= 1'b1;
                state_reg <= M_PA;
              end
              CMD_WRITE: begin
                tx_reg <= {cmd_data_in, 1'b1};  // Release for slave acknowledge
                state_reg <= M_BL;
              end
              default: begin
                tx_reg <= {8'hff, ~cmd_ack_in};  // see RULE12
                state_reg <= M_BL;
              end
            endcase
          end
        end
        // Start: release, clock high, data falls while clock high, clock low
        M_SA: if (tick) begin
          scl_reg <= 1'b1;
          state_reg <= M_SB;
        end
        M_SB: if (tick) begin
          sda_low_reg <= 1'b1;  // see RULE7
          state_reg <= M_SC;
        end
        M_SC: if (tick) begin
          scl_reg <= 1'b0;
          state_reg <= M_SD;
        end
        M_SD: if (tick) begin
          done_reg <= 1'b1;
          state_reg <= M_IDLE;
        end
        // Stop: data low, clock high, data rises while clock high
        M_PA: if (tick) begin
          scl_reg <= 1'b1;
          state_reg <= M_PB;
        end
        M_PB: if (tick) begin
          sda_low_reg <= 1'b0;  // see RULE11
          state_reg <= M_PC;
        end
        M_PC: if (tick) begin
          done_reg <= 1'b1;
          state_reg <= M_IDLE;
        end
        // Bit low phase: data changes one cycle after the clock fell
        M_BL: begin
          if (tmr_reg == 8'h00) begin
            sda_low_reg <= ~tx_reg[8];  // see RULE3
          end
          if (tick) begin
            scl_reg <= 1'b1;
            state_reg <= M_BH;
          end
        end
        // Bit high phase: sample at its end, then drop the clock
        M_BH: if (tick) begin
          scl_reg <= 1'b0;
          rx_reg <= {rx_reg[6:0], sda_sync2_reg};
          tx_reg <= {tx_reg[7:0], 1'b1};
          if (bit_reg == BIT_DATA_LAST) begin
            rsp_data_reg <= rx_reg;
            rsp_ack_reg <= ~sda_sync2_reg;
            done_reg <= 1'b1;
            state_reg <= M_IDLE;
          end else begin
            bit_reg <= bit_reg + BIT_FIRST;
            state_reg <= M_BL;
          end
        end
        default: state_reg <= M_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign cmd_ready_out = (state_reg == M_IDLE);
  assign done_out = done_reg;
  assign rsp_data_out = rsp_data_reg;
  assign rsp_ack_out = rsp_ack_reg;
  assign link.scl = scl_reg;
  assign link.m_sda_out = 1'b0;
  assign link.m_sda_oe = sda_low_reg;

endmodule

// ---- sim/sebfe_chk.sv ----
// Assertion checker for the two-wire link between the master and slave ends.
// Takes the link signals as plain inputs; the bench instantiates it beside the link.
`timescale 1ns/10ps
module sebfe_chk
  import sebfe_pkg::*;
#(
  parameter logic [3:0] TYPE_CODE = TYPE_CODE_DEFAULT,
  parameter logic [2:0] SELECT_CODE = SELECT_DEFAULT
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // Link signals
  input wire logic scl,
  input wire logic sda,
  input wire logic m_sda_out,
  input wire logic m_sda_oe,
  input wire logic d_sda_out,
  input wire logic d_sda_oe
);
  logic scl_reg;
  logic sda_reg;
  logic first_byte_reg;
  logic rise;
  logic edge_hi;
  logic [3:0] cnt_reg;
  logic [7:0] addr_sr_reg;

  //////////////////////////////////////
  // Bus events from the previous sample
  assign rise = scl & ~scl_reg;
  assign edge_hi = scl & scl_reg & (sda != sda_reg);

  // Bit count within a byte and capture of the first byte
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      cnt_reg <= 4'h0;
      first_byte_reg <= 1'b0;
      addr_sr_reg <= 8'h00;
    end else begin
      scl_reg <= scl;
      sda_reg <= sda;
      if (edge_hi) begin
        cnt_reg <= 4'h0;
        first_byte_reg <= ~sda;
      end else if (rise) begin
        cnt_reg <= (cnt_reg == 4'h9) ? 4'h1 : cnt_reg + 4'h1;
        addr_sr_reg <= {addr_sr_reg[6:0], sda};
        if (cnt_reg == 4'h9) begin
          first_byte_reg <= 1'b0;
        end
      end
    end
  end

  //////////////////////////////////////
  // Properties
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);

  sequence s_start;
    scl && $fell(sda);
  endsequence
  sequence s_ninth_addr;
    rise && (cnt_reg == 4'h8) && first_byte_reg;
  endsequence

  a_open_drain_low: assert property ((d_sda_oe || m_sda_oe) |->
    !sda && !d_sda_out && !m_sda_out)
    else $error("data line not pulled low by an enabled driver");
  a_reset_bus_idle: assert property ($rose(resetn_in) |->
    scl && !m_sda_oe && !d_sda_oe)
    else $error("bus not idle after reset");
  a_start_clock_high: assert property (s_start |-> $past(scl))
    else $error("data fell while clock was not held high");
  a_data_stable_rise: assert property ($rose(scl) |-> $stable(sda))
    else $error("data changed at a clock rise");
  a_slave_change_low: assert property ($changed(d_sda_oe) |-> !scl && !scl_reg)
    else $error("slave changed its drive while clock high");
  a_scl_high_min: assert property ($rose(scl) |=> scl [*8])
    else $error("clock high phase too short");
  a_scl_low_min: assert property ($fell(scl) |=> !scl [*8])
    else $error("clock low phase too short");
  a_addr_byte_quiet: assert property (first_byte_reg && (cnt_reg < 4'h8) |->
    !d_sda_oe)
    else $error("slave drove during the address byte");
  a_addr_nack_other: assert property (s_ninth_addr ##0
    (addr_sr_reg[7:1] != {TYPE_CODE, SELECT_CODE}) |-> !d_sda_oe)
    else $error("slave acknowledged a foreign address");
endmodule

// ---- sim/serial_eeprom_bus_front_end_bench.sv ----
// Bench joining the master end and the slave end over one link, with a memory model.
// Runs the whole suite in each speed grade; shortened program time.
`timescale 1ns/10ps
module serial_eeprom_bus_front_end_bench
  import sebfe_pkg::*;
;
  localparam int PROG = 3000;
  localparam logic [7:0] AW = {TYPE_CODE_DEFAULT, SELECT_DEFAULT, 1'b0};
  localparam logic [7:0] AR = {TYPE_CODE_DEFAULT, SELECT_DEFAULT, 1'b1};
  logic clk_sys_in, resetn_in, wp_in, cmd_valid_in, cmd_ack_in, cmd_ready_out, done_out;
  logic rsp_ack_out, prog_out, protect_refused_out, busy_out;
  sebfe_cmd_type cmd_kind_in;
  sebfe_grade_type grade_in;
  logic [7:0] cmd_data_in, rsp_data_out, rd_data_in, prog_data_out;
  logic [11:0] rd_addr_out, prog_addr_out;
  logic [7:0] mem [0:4095];
  int errors, num_checks, busy_len, prog_cnt, ref_cnt;
  sebfe_link_if link ();

  //////////////////////////////////////
  // Clock and design instances
  always #25 clk_sys_in = ~clk_sys_in;
  assign rd_data_in = mem[rd_addr_out];

  sebfe_master_end sebfe_master_end_i (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out), .cmd_kind_in(cmd_kind_in),
    .cmd_data_in(cmd_data_in), .cmd_ack_in(cmd_ack_in), .grade_in(grade_in),
    .done_out(done_out), .rsp_data_out(rsp_data_out), .rsp_ack_out(rsp_ack_out), .link(link));
  sebfe_slave_end #(.PROG_CYCLES(PROG)) sebfe_slave_end_i (.clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in), .link(link), .wp_in(wp_in), .rd_addr_out(rd_addr_out),
    .rd_data_in(rd_data_in), .prog_out(prog_out), .prog_addr_out(prog_addr_out),
    .prog_data_out(prog_data_out), .protect_refused_out(protect_refused_out),
    .busy_out(busy_out));
  sebfe_chk sebfe_chk_i (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .scl(link.scl),
    .sda(link.sda), .m_sda_out(link.m_sda_out), .m_sda_oe(link.m_sda_oe),
    .d_sda_out(link.d_sda_out), .d_sda_oe(link.d_sda_oe));

  // Memory array model and event counters
  always @(posedge clk_sys_in) begin
    if (prog_out === 1'b1) begin
      mem[prog_addr_out] <= prog_data_out;
      prog_cnt++;
    end
    if (protect_refused_out === 1'b1) ref_cnt++;
    if (busy_out === 1'b1) busy_len++;
  end

  //////////////////////////////////////
  // Compare, report and command tasks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One command, held for one clock cycle, then a bounded wait for done
  task automatic cmd(input sebfe_cmd_type k, input logic [7:0] d, input logic a);
    int n;
    @(posedge clk_sys_in);
    cmd_valid_in <= 1'b1;
    cmd_kind_in <= k;
    cmd_data_in <= d;
    cmd_ack_in <= a;
    @(posedge clk_sys_in);
    cmd_valid_in <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      #1;
      n++;
      if (n == 1) chk_bit(cmd_ready_out, 1'b0);
    end while (done_out !== 1'b1 && n < 4000);
    if (done_out !== 1'b1) begin
      errors++;
      tally_and_finish();
    end
    chk_bit(cmd_ready_out, 1'b1);
    @(posedge clk_sys_in);
  endtask

  task automatic wr(input logic [7:0] d, input logic e);
    cmd(CMD_WRITE, d, 1'b0);
    chk_bit(rsp_ack_out, e);
  endtask

  task automatic rd(input logic a, input logic [7:0] e);
    cmd(CMD_READ, 8'hff, a);
    chk_val({8'h00, rsp_data_out}, {8'h00, e});
    chk_bit(rsp_ack_out, a);
  endtask

  // Start, address byte, then the memory address 0x123
  task automatic at_123();
    cmd(CMD_START, 8'h00, 1'b0);
    wr(AW, 1'b1);
    wr(8'h01, 1'b1);
    wr(8'h23, 1'b1);
  endtask

  //////////////////////////////////////
  // Main sequence
  initial begin
    int g, p0, r0, n;
    clk_sys_in = 1'b0;
    resetn_in = 1'b0;
    wp_in = 1'b0;
    cmd_valid_in = 1'b0;
    cmd_kind_in = CMD_START;
    cmd_data_in = 8'h00;
    cmd_ack_in = 1'b0;
    grade_in = GRADE_STD;
    {errors, num_checks, busy_len, prog_cnt, ref_cnt} = '0;
    for (n = 0; n < 4096; n++) mem[n] = n[7:0] ^ 8'h5a;
    repeat (3) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    repeat (5) @(posedge clk_sys_in);
    for (g = 0; g < 3; g++) begin
      grade_in <= sebfe_grade_type'(g);
      // Unprotected write, then an address poll while programming
      wp_in <= 1'b0;
      p0 = prog_cnt;
      busy_len = 0;
      at_123();
      wr(8'ha5, 1'b1);
      cmd(CMD_STOP, 8'h00, 1'b0);
      for (n = 0; n < 40 && prog_cnt == p0; n++) @(posedge clk_sys_in);
      chk_val(16'(prog_cnt - p0), 16'h0001);
      chk_val({4'h0, prog_addr_out}, 16'h0123);
      chk_val({8'h00, prog_data_out}, 16'h00a5);
      chk_bit(busy_out, 1'b1);
      cmd(CMD_START, 8'h00, 1'b0);
      wr(AW, 1'b0);
      cmd(CMD_STOP, 8'h00, 1'b0);
      for (n = 0; n < PROG + 50 && busy_out !== 1'b0; n++) begin
        @(posedge clk_sys_in);
        #1;
      end
      chk_val(16'(busy_len), 16'(PROG));
      $display("test write grade %0d done", g);
      // Random read with protection on, master ack then no ack
      @(posedge clk_sys_in);
      wp_in <= 1'b1;
      at_123();
      cmd(CMD_START, 8'h00, 1'b0);
      wr(AR, 1'b1);
      rd(1'b1, 8'ha5);
      rd(1'b0, 8'h24 ^ 8'h5a);
      cmd(CMD_STOP, 8'h00, 1'b0);
      chk_val({4'h0, rd_addr_out}, 16'h0125);
      $display("test read grade %0d done", g);
      // Protected write is refused and leaves memory unchanged
      p0 = prog_cnt;
      r0 = ref_cnt;
      at_123();
      wr(8'h3c, 1'b1);
      cmd(CMD_STOP, 8'h00, 1'b0);
      for (n = 0; n < 40 && ref_cnt == r0; n++) @(posedge clk_sys_in);
      chk_val(16'(ref_cnt - r0), 16'h0001);
      chk_val(16'(prog_cnt - p0), 16'h0000);
      chk_bit(busy_out, 1'b0);
      at_123();
      cmd(CMD_START, 8'h00, 1'b0);
      wr(AR, 1'b1);
      rd(1'b0, 8'ha5);
      cmd(CMD_STOP, 8'h00, 1'b0);
      $display("test protect grade %0d done", g);
      // Foreign type code and foreign select field get no acknowledge
      for (n = 0; n < 2; n++) begin
        cmd(CMD_START, 8'h00, 1'b0);
        wr((n == 0) ? {TYPE_CODE_DEFAULT, SELECT_DEFAULT ^ 3'h1, 1'b0}
                    : {TYPE_CODE_DEFAULT ^ 4'h1, SELECT_DEFAULT, 1'b0}, 1'b0);
        cmd(CMD_STOP, 8'h00, 1'b0);
      end
      $display("test address grade %0d done", g);
    end
    tally_and_finish();
  end
endmodule
